// *** logic/rtm_cfg_bank.sv ***
// Writable configuration words of the map, one register per word
`timescale 1ns/1ns

module rtm_cfg_bank
   import rtm_pkg::*;
(
   // Clock and reset
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst,
   // Write port
   input  wire logic                           i_wr_en,
   input  wire logic [rtm_pkg::RTM_ADDR_W-1:0] i_wr_addr,
   input  wire logic [rtm_pkg::RTM_WORD_W-1:0] i_wr_data,
   // Stored words, lowest offset first
   output logic [rtm_pkg::RTM_WORD_W-1:0]      o_word [rtm_pkg::RTM_CFG_NUM]
);
   import rtm_pkg::*;

   localparam logic [RTM_WORD_W-1:0] RST_VAL [RTM_CFG_NUM] = '{
      RTM_RST_PT_CFG, RTM_RST_FMT_CFG, RTM_RST_AVG_CFG, RTM_RST_ALM_CFG, RTM_RST_UNIT_CFG
   };

   // ------------------------------------------------------------
   // One register per configuration word
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < RTM_CFG_NUM; g++) begin : g_word
         logic [RTM_WORD_W-1:0] word_r;
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               word_r <= RST_VAL[g];
            end else if (i_wr_en && i_wr_addr == RTM_OFS_PT_CFG + RTM_ADDR_W'(g)) begin
               word_r <= i_wr_data;
            end
         end
         assign o_word[g] = word_r;
      end
   endgenerate

endmodule : rtm_cfg_bank

// *** logic/rtm_pkg.sv ***
// Constants for the temperature module status and configuration map
package rtm_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int          RTM_POINTS   = 8;
   localparam int          RTM_WORD_W   = 16;
   localparam int          RTM_ADDR_W   = 8;
   localparam int          RTM_CFG_NUM  = 5;

   // ------------------------------------------------------------
   // Word offsets in the map
   // ------------------------------------------------------------
   localparam logic [7:0]  RTM_OFS_PEAK_STAT  = 8'h13;
   localparam logic [7:0]  RTM_OFS_FMT_STAT   = 8'h14;
   localparam logic [7:0]  RTM_OFS_AVG_STAT   = 8'h15;
   localparam logic [7:0]  RTM_OFS_ALM_STAT   = 8'h16;
   localparam logic [7:0]  RTM_OFS_UNIT_STAT  = 8'h17;
   localparam logic [7:0]  RTM_OFS_POINTER    = 8'h18;
   localparam logic [7:0]  RTM_OFS_PT_CFG     = 8'h19;
   localparam logic [7:0]  RTM_OFS_FMT_CFG    = 8'h1A;
   localparam logic [7:0]  RTM_OFS_AVG_CFG    = 8'h1B;
   localparam logic [7:0]  RTM_OFS_ALM_CFG    = 8'h1C;
   localparam logic [7:0]  RTM_OFS_UNIT_CFG   = 8'h1D;

   // ------------------------------------------------------------
   // Field positions: low byte and high byte of a word
   // ------------------------------------------------------------
   localparam int          RTM_LO_LSB   = 0;
   localparam int          RTM_HI_LSB   = 8;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   // Points all enabled, peak hold all disabled
   localparam logic [15:0] RTM_RST_PT_CFG   = 16'h00FF;
   // Packed decimal (1) for every point, scaling off
   localparam logic [15:0] RTM_RST_FMT_CFG  = 16'h00FF;
   localparam logic [15:0] RTM_RST_AVG_CFG  = 16'h0000;
   localparam logic [15:0] RTM_RST_ALM_CFG  = 16'h0000;
   localparam logic [15:0] RTM_RST_UNIT_CFG = 16'h0000;
   localparam logic [15:0] RTM_RST_POINTER  = 16'h0000;
   localparam logic [15:0] RTM_RST_STAT     = 16'h0000;

   // Format select encoding
   localparam logic        RTM_FMT_BCD    = 1'b1;
   localparam logic        RTM_FMT_BINARY = 1'b0;

   // Transfer direction state
   typedef enum logic [1:0] {
      RTM_XF_IDLE,
      RTM_XF_READ,
      RTM_XF_WRITE
   } rtm_xfer_t;

endpackage : rtm_pkg

// *** logic/rtm_status_map.sv ***
// Status mirror, start pointer and block transfer port of the map
//
// Notes on behaviour
// - Word 19 high byte mirrors peak hold enables from word 25 high byte.
// - Word 20 low byte mirrors per-point output format from word 26 low byte.
// - Word 20 high byte mirrors scaling enables from word 26 high byte.
// - Word 21 low byte mirrors averaging enables from word 27 low byte.
// - Word 21 high byte mirrors filtering enables from word 27 high byte.
// - Word 22 low byte mirrors low alarm enables from word 28 low byte.
// - Word 22 high byte mirrors high alarm enables from word 28 high byte.
// - Word 23 low byte mirrors Celsius/Fahrenheit choice from word 29 low byte.
// - Word 24 is a writable pointer; every block transfer starts at the word it points to.
// - Format bit one selects packed decimal, zero selects binary.
// - Peak hold enables in word 25 high byte reset to zero.
`timescale 1ns/1ns

module rtm_status_map
   import rtm_pkg::*;
(
   // Clock and reset
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst,
   // Block transfer from host
   input  wire logic                           i_xfer_start,
   input  wire logic                           i_word_wr,
   input  wire logic [rtm_pkg::RTM_WORD_W-1:0] i_word_wdata,
   input  wire logic                           i_word_rd,
   output logic [rtm_pkg::RTM_WORD_W-1:0]      o_rd_data,
   output logic                                o_rd_valid,
   output logic [rtm_pkg::RTM_ADDR_W-1:0]      o_xfer_addr,
   // Configuration towards conversion logic
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_scan_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_peak_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_fmt_bcd,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_scale_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_avg_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_filt_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_lo_alarm_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_hi_alarm_enable,
   output logic [rtm_pkg::RTM_POINTS-1:0]      o_unit_select
);
   import rtm_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [RTM_WORD_W-1:0] cfg_word [RTM_CFG_NUM];
   logic [RTM_WORD_W-1:0] pointer_r;
   logic [RTM_ADDR_W-1:0] addr_r;
   logic [RTM_ADDR_W-1:0] addr_nxt;
   logic [RTM_ADDR_W-1:0] cur_addr;
   logic [RTM_WORD_W-1:0] stat_r [5];
   logic [RTM_WORD_W-1:0] stat_nxt [5];
   logic [RTM_WORD_W-1:0] rd_word;
   logic [RTM_WORD_W-1:0] rd_data_r;
   logic                  rd_valid_r;
   rtm_xfer_t             xfer_r;
   rtm_xfer_t             xfer_nxt;

   // ------------------------------------------------------------
   // Transfer address
   // ------------------------------------------------------------
   // start at pointer
   // A start and a word access in one cycle use the pointer directly
   assign cur_addr = i_xfer_start ? pointer_r[RTM_ADDR_W-1:0] : addr_r;

   always_comb begin
      addr_nxt = cur_addr;
      if (i_word_wr || i_word_rd) begin
         addr_nxt = cur_addr + RTM_ADDR_W'(1);
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_r <= '0;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   // Direction is tracked for observation only after the first access
   always_comb begin
      xfer_nxt = xfer_r;
      case (xfer_r)
         RTM_XF_IDLE,
         RTM_XF_READ,
         RTM_XF_WRITE: begin
            if (i_word_wr) begin
               xfer_nxt = RTM_XF_WRITE;
            end else if (i_word_rd) begin
               xfer_nxt = RTM_XF_READ;
            end else if (i_xfer_start) begin
               xfer_nxt = RTM_XF_IDLE;
            end
         end
         default: xfer_nxt = RTM_XF_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         xfer_r <= RTM_XF_IDLE;
      end else begin
         xfer_r <= xfer_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pointer word
   // ------------------------------------------------------------
   // writable pointer
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pointer_r <= RTM_RST_POINTER;
      end else if (i_word_wr && cur_addr == RTM_OFS_POINTER) begin
         pointer_r <= i_word_wdata;
      end
   end

   // ------------------------------------------------------------
   // Configuration words 25 to 29
   // ------------------------------------------------------------
   rtm_cfg_bank u_cfg (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_wr_en    (i_word_wr),
      .i_wr_addr  (cur_addr),
      .i_wr_data  (i_word_wdata),
      .o_word     (cfg_word)
   );

   // ------------------------------------------------------------
   // Status mirror, words 19 to 23
   // ------------------------------------------------------------
   always_comb begin
      stat_nxt[0][RTM_HI_LSB +: 8] = cfg_word[0][RTM_HI_LSB +: 8];
      stat_nxt[0][RTM_LO_LSB +: 8] = cfg_word[0][RTM_LO_LSB +: 8];
      stat_nxt[1][RTM_LO_LSB +: 8] = cfg_word[1][RTM_LO_LSB +: 8];
      stat_nxt[1][RTM_HI_LSB +: 8] = cfg_word[1][RTM_HI_LSB +: 8];
      stat_nxt[2][RTM_LO_LSB +: 8] = cfg_word[2][RTM_LO_LSB +: 8];
      stat_nxt[2][RTM_HI_LSB +: 8] = cfg_word[2][RTM_HI_LSB +: 8];
      stat_nxt[3][RTM_LO_LSB +: 8] = cfg_word[3][RTM_LO_LSB +: 8];
      stat_nxt[3][RTM_HI_LSB +: 8] = cfg_word[3][RTM_HI_LSB +: 8];
      stat_nxt[4][RTM_LO_LSB +: 8] = cfg_word[4][RTM_LO_LSB +: 8];
      stat_nxt[4][RTM_HI_LSB +: 8] = 8'h00;
   end

   // host writes ignored
   // Status follows configuration one cycle late, never the bus
   genvar s;
   generate
      for (s = 0; s < 5; s++) begin : g_stat
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               stat_r[s] <= RTM_RST_STAT;
            end else begin
               stat_r[s] <= stat_nxt[s];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      case (cur_addr)
         RTM_OFS_PEAK_STAT: rd_word = stat_r[0];
         RTM_OFS_FMT_STAT:  rd_word = stat_r[1];
         RTM_OFS_AVG_STAT:  rd_word = stat_r[2];
         RTM_OFS_ALM_STAT:  rd_word = stat_r[3];
         RTM_OFS_UNIT_STAT: rd_word = stat_r[4];
         RTM_OFS_POINTER:   rd_word = pointer_r;
         RTM_OFS_PT_CFG:    rd_word = cfg_word[0];
         RTM_OFS_FMT_CFG:   rd_word = cfg_word[1];
         RTM_OFS_AVG_CFG:   rd_word = cfg_word[2];
         RTM_OFS_ALM_CFG:   rd_word = cfg_word[3];
         RTM_OFS_UNIT_CFG:  rd_word = cfg_word[4];
         // Words held elsewhere read as zero here
         default:           rd_word = '0;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_data_r  <= '0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= i_word_rd;
         if (i_word_rd) begin
            rd_data_r <= rd_word;
         end
      end
   end

   assign o_rd_data   = rd_data_r;
   assign o_rd_valid  = rd_valid_r;
   assign o_xfer_addr = addr_r;

   // ------------------------------------------------------------
   // Configuration outputs
   // ------------------------------------------------------------
   // scan only enabled
   assign o_scan_enable     = cfg_word[0][RTM_LO_LSB +: 8];
   assign o_peak_enable     = cfg_word[0][RTM_HI_LSB +: 8];
   assign o_fmt_bcd         = cfg_word[1][RTM_LO_LSB +: 8];
   assign o_scale_enable    = cfg_word[1][RTM_HI_LSB +: 8];
   assign o_avg_enable      = cfg_word[2][RTM_LO_LSB +: 8];
   assign o_filt_enable     = cfg_word[2][RTM_HI_LSB +: 8];
   assign o_lo_alarm_enable = cfg_word[3][RTM_LO_LSB +: 8];
   assign o_hi_alarm_enable = cfg_word[3][RTM_HI_LSB +: 8];
   assign o_unit_select     = cfg_word[4][RTM_LO_LSB +: 8];

endmodule : rtm_status_map

// *** sim/rtm_host_model.sv ***
// Host model issuing single-word transfers
`timescale 1ns/1ns
module rtm_host_model
   import rtm_pkg::*;
(
   // Clock and answers
   input  wire logic                           i_core_clk,
   input  wire logic [rtm_pkg::RTM_WORD_W-1:0] i_rd_data,
   input  wire logic                           i_rd_valid,
   // Requests
   output logic                                o_xfer_start,
   output logic                                o_word_wr,
   output logic                                o_word_rd,
   output logic [rtm_pkg::RTM_WORD_W-1:0]      o_word_wdata
);
   initial begin
      {o_xfer_start, o_word_wr, o_word_rd} = 3'h0;
      o_word_wdata = 16'hA5A5;
   end
   task automatic word(input logic st, input logic wr, input logic [15:0] d, output logic [15:0] q);
      @(negedge i_core_clk);
      o_xfer_start = st;
      o_word_wr    = wr;
      o_word_rd    = !wr;
      o_word_wdata = d;
      @(negedge i_core_clk);
      q = i_rd_valid ? i_rd_data : 16'h0BAD;
      {o_xfer_start, o_word_wr, o_word_rd} = 3'h0;
      // Data not held past its strobe
      o_word_wdata = ~d;
   endtask
endmodule // rtm_host_model

// *** sim/rtm_status_map_monitor.sv ***
// Port checker for the status map
`timescale 1ns/1ns
module rtm_status_map_chk
   import rtm_pkg::*;
(
   // Clock, reset and transfer port
   input wire logic                           i_core_clk,
   input wire logic                           i_rst,
   input wire logic                           i_xfer_start,
   input wire logic                           i_word_wr,
   input wire logic [rtm_pkg::RTM_WORD_W-1:0] i_word_wdata,
   input wire logic                           i_word_rd,
   input wire logic [rtm_pkg::RTM_WORD_W-1:0] o_rd_data,
   input wire logic                           o_rd_valid,
   input wire logic [rtm_pkg::RTM_ADDR_W-1:0] o_xfer_addr,
   // Configuration outputs
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_scan_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_peak_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_fmt_bcd,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_scale_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_avg_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_filt_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_lo_alarm_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_hi_alarm_enable,
   input wire logic [rtm_pkg::RTM_POINTS-1:0] o_unit_select
);
   wire logic [71:0] cfg_all = {o_scan_enable, o_peak_enable, o_fmt_bcd, o_scale_enable, o_avg_enable,
                                o_filt_enable, o_lo_alarm_enable, o_hi_alarm_enable, o_unit_select};
   wire logic        acc = i_word_rd || i_word_wr;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Mirrors lag config one cycle, so only settled config is judged
   sequence s_rd(logic [7:0] a);
      i_word_rd && !i_xfer_start && o_xfer_addr == a && !$past(i_rst) && $stable(cfg_all);
   endsequence
   property p_rd_answer; i_word_rd |=> o_rd_valid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_addr_step; acc && !i_xfer_start |=> o_xfer_addr == $past(o_xfer_addr) + 8'h01; endproperty
   a_addr_step: assert property (p_addr_step) else $error("address did not step");
   property p_peak_mirror; s_rd(8'h13) |=> o_rd_data == $past({o_peak_enable, o_scan_enable}); endproperty
   a_peak_mirror: assert property (p_peak_mirror) else $error("word 19 wrong");
   property p_fmt_mirror; s_rd(8'h14) |=> o_rd_data == $past({o_scale_enable, o_fmt_bcd}); endproperty
   a_fmt_mirror: assert property (p_fmt_mirror) else $error("word 20 wrong");
   property p_avg_mirror; s_rd(8'h15) |=> o_rd_data == $past({o_filt_enable, o_avg_enable}); endproperty
   a_avg_mirror: assert property (p_avg_mirror) else $error("word 21 wrong");
   property p_alm_mirror; s_rd(8'h16) |=> o_rd_data == $past({o_hi_alarm_enable, o_lo_alarm_enable}); endproperty
   a_alm_mirror: assert property (p_alm_mirror) else $error("word 22 wrong");
   property p_unit_mirror; s_rd(8'h17) |=> o_rd_data == {8'h00, $past(o_unit_select)}; endproperty
   a_unit_mirror: assert property (p_unit_mirror) else $error("word 23 wrong");
   property p_stat_wr; i_word_wr && !i_xfer_start && o_xfer_addr inside {[8'h13:8'h17]} |=> $stable(cfg_all);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status write took effect");
   property p_scan_wr; i_word_wr && !i_xfer_start && o_xfer_addr == 8'h19 |=>
      {o_peak_enable, o_scan_enable} == $past(i_word_wdata); endproperty
   a_scan_wr: assert property (p_scan_wr) else $error("word 25 not stored");
   property p_rst_defaults; $fell(i_rst) |->
      {o_peak_enable, o_scan_enable} == RTM_RST_PT_CFG && !o_rd_valid && o_xfer_addr == 8'h00; endproperty
   a_rst_defaults: assert property (p_rst_defaults) else $error("reset defaults wrong");
   c_burst: cover property (i_word_rd ##2 i_word_rd && !i_xfer_start);
   c_ptr_wr: cover property (i_word_wr && o_xfer_addr == 8'h18);
   c_stat_wr: cover property (i_word_wr && o_xfer_addr == 8'h13);
endmodule // rtm_status_map_chk

bind rtm_status_map rtm_status_map_chk u_chk (.i_core_clk, .i_rst, .i_xfer_start, .i_word_wr, .i_word_wdata,
   .i_word_rd, .o_rd_data, .o_rd_valid, .o_xfer_addr, .o_scan_enable, .o_peak_enable, .o_fmt_bcd,
   .o_scale_enable, .o_avg_enable, .o_filt_enable, .o_lo_alarm_enable, .o_hi_alarm_enable, .o_unit_select);

// *** sim/test_rtm_status_map.sv ***
// Self-checking bench for the status map
`timescale 1ns/1ns
module test_rtm_status_map;
   import rtm_pkg::*;
   typedef struct packed {logic [4:0][15:0] cfg; logic [4:0][15:0] st;} rtm_row_t;
   logic        i_core_clk, i_rst, xs, ww, wrd, rv;
   logic [15:0] wd, rd, q;
   logic [7:0]  xa, scan, peak, fmt, scl, avg, filt, lo, hi, unit;
   int          mismatches, comparisons, cycles;
   rtm_row_t    rows [3];
   rtm_status_map dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_xfer_start(xs), .i_word_wr(ww),
      .i_word_wdata(wd), .i_word_rd(wrd), .o_rd_data(rd), .o_rd_valid(rv), .o_xfer_addr(xa),
      .o_scan_enable(scan), .o_peak_enable(peak), .o_fmt_bcd(fmt), .o_scale_enable(scl),
      .o_avg_enable(avg), .o_filt_enable(filt), .o_lo_alarm_enable(lo), .o_hi_alarm_enable(hi),
      .o_unit_select(unit));
   rtm_host_model host (.i_core_clk(i_core_clk), .i_rd_data(rd), .i_rd_valid(rv), .o_xfer_start(xs),
      .o_word_wr(ww), .o_word_rd(wrd), .o_word_wdata(wd));
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Burst from 0x12: dead word, five status, pointer, five config
   function automatic logic [15:0] xexp(int r, int k, logic rdn);
      if (k == 0) return rdn ? 16'h0000 : 16'hFFFF;
      if (k < 6) return rdn ? rows[r].st[k-1] : 16'hFFFF;
      if (k == 6) return 16'h0012;
      return rows[r].cfg[k-7];
   endfunction
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      {mismatches, comparisons, cycles} = 0;
      rows[0] = {80'h0000_0000_0000_00FF_00FF, 80'h0000_0000_0000_00FF_00FF};
      rows[1] = {80'hFF96_F05A_5A0F_3CC3_A55A, 80'h0096_F05A_5A0F_3CC3_A55A};
      rows[2] = {80'h0001_00FF_8001_0001_0F00, 80'h0001_00FF_8001_0001_0F00};
      i_rst = 1'b1;
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      // Walk up to the pointer; writes below it must be dropped
      for (int i = 0; i <= 24; i++)
         host.word(i == 0, 1'b1, (i == 24) ? 16'h0012 : 16'hFFFF, q);
      for (int r = 0; r < 3; r++) begin
         if (r > 0)
            for (int k = 0; k < 12; k++)
               host.word(k == 0, 1'b1, xexp(r, k, 1'b0), q);
         for (int k = 0; k < 12; k++) begin
            host.word(k == 0, 1'b0, 16'h0000, q);
            chk(72'(q), 72'(xexp(r, k, 1'b1)));
         end
         chk({hi, lo, filt, avg, scl, fmt, peak, scan, unit}, {rows[r].cfg[3:0], rows[r].cfg[4][7:0]});
         chk(72'(xa), 72'h1E);
      end
      // Mid-run reset must restore the defaults over written values
      @(negedge i_core_clk);
      i_rst = 1'b1;
      repeat (5) @(negedge i_core_clk);
      chk(72'({peak, scan, xa, rv}), 72'({RTM_RST_PT_CFG, 8'h00, 1'b0}));
      i_rst = 1'b0;
      // Pointer is back at zero, so a fresh read starts there
      host.word(1'b1, 1'b0, 16'h0000, q);
      chk(72'({q, xa}), 72'h01);
      wrap_up();
   end
endmodule // test_rtm_status_map
